// ===== hdl/ctl_sel_pkg.sv
// constants, types and register map of the control method selector
package ctl_sel_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYCLES_PER_MS = CLK_HZ / MS_PER_S;
  // worst latency allowed from a speed select edge to its effect
  localparam int unsigned SEL_LATENCY_MS = 2;
  localparam int unsigned SEL_LATENCY_CYC =
    (CLK_HZ / MS_PER_S) * SEL_LATENCY_MS;
  localparam int unsigned SYNC_STAGES = 2;

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam logic [7:0] METHOD_SEL_OFS = 8'h00;
  localparam logic [7:0] ALLOC_OFS = 8'h01;
  localparam logic [7:0] SPEED_ONE_OFS = 8'h02;
  localparam logic [7:0] SPEED_TWO_OFS = 8'h03;
  localparam logic [7:0] SPEED_THREE_OFS = 8'h04;
  localparam logic [7:0] DECEL_TIME_OFS = 8'h05;
  localparam logic [7:0] MAX_SPEED_OFS = 8'h06;
  localparam logic [7:0] STATUS_OFS = 8'h07;
  localparam logic [7:0] RESTART_OFS = 8'h08;

  // ---------------------------------------------------------------
  // reset values and the settable speed limit
  // ---------------------------------------------------------------
  localparam logic [3:0] METHOD_SEL_RST = 4'h4;
  localparam logic ALLOC_RST = 1'b0;
  localparam logic [15:0] SPEED_ONE_RST = 16'h0064;
  localparam logic [15:0] SPEED_TWO_RST = 16'h00c8;
  localparam logic [15:0] SPEED_THREE_RST = 16'h012c;
  localparam logic [15:0] DECEL_TIME_RST = 16'h0000;
  localparam logic [15:0] MAX_SPEED_RST = 16'h2710;
  localparam logic [15:0] SPEED_LIMIT = 16'h2710;

  // ---------------------------------------------------------------
  // method selection codes
  // ---------------------------------------------------------------
  localparam logic [3:0] CODE_SPEED = 4'h0;
  localparam logic [3:0] CODE_POSITION = 4'h1;
  localparam logic [3:0] CODE_TORQUE = 4'h2;
  localparam logic [3:0] CODE_INTERNAL = 4'h3;
  localparam logic [3:0] CODE_INT_SPEED = 4'h4;
  localparam logic [3:0] CODE_INT_POS = 4'h5;
  localparam logic [3:0] CODE_INT_TORQUE = 4'h6;
  localparam logic [3:0] CODE_POS_SPEED = 4'h7;
  localparam logic [3:0] CODE_POS_TORQUE = 4'h8;
  localparam logic [3:0] CODE_TORQUE_SPEED = 4'h9;
  localparam logic [3:0] CODE_ZERO_CLAMP = 4'ha;
  localparam logic [3:0] CODE_INHIBIT = 4'hb;

  // status register field positions
  localparam int unsigned ST_METHOD_LSB = 0;
  localparam int unsigned ST_REVERSE_BIT = 6;
  localparam int unsigned ST_DECEL_BIT = 7;
  localparam int unsigned ST_CODE_LSB = 8;
  localparam int unsigned ST_ALLOC_BIT = 12;

  // active control method, one-hot
  typedef enum logic [5:0] {
    M_INTERNAL = 6'h01,
    M_SPEED = 6'h02,
    M_POSITION = 6'h04,
    M_TORQUE = 6'h08,
    M_ZERO_CLAMP = 6'h10,
    M_INHIBIT = 6'h20
  } method_t;

  // sequence input contacts, true = contact on
  typedef struct packed {
    logic direction_select_in;
    logic speed_select_a_in;
    logic speed_select_b_in;
    logic dedicated_direction_in;
    logic dedicated_speed_a_in;
    logic dedicated_speed_b_in;
    logic control_switch_in;
    logic zero_clamp_in;
    logic pulse_inhibit_in;
  } seq_in_t;

  // drive command towards the control loops
  typedef struct packed {
    method_t method;
    logic [15:0] speed_ref;
    logic reverse;
    logic decel;
  } drive_cmd_t;

endpackage : ctl_sel_pkg

// ===== hdl/seq_in_sync.sv
// two-stage synchroniser for the sequence input contacts
`timescale 1ns/1ps
module seq_in_sync (
  input wire logic clk_i,                          // control clock
  input wire logic reset_n_i,                      // async reset, low
  input wire ctl_sel_pkg::seq_in_t async_i,        // raw contacts
  output ctl_sel_pkg::seq_in_t sync_o              // synchronised contacts
);
  localparam int unsigned W = $bits(ctl_sel_pkg::seq_in_t);
  logic [W-1:0] meta_q;
  logic [W-1:0] stable_q;

  // ---------------------------------------------------------------
  // per-bit flops; the first stage feeds only the second
  // ---------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        meta_q[i] <= 1'b0;
        stable_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= async_i[i];
        stable_q[i] <= meta_q[i];
      end
    end
  end

  assign sync_o = stable_q;

endmodule : seq_in_sync

// ===== hdl/speed_clamp.sv
// limits a set speed to the settable range and the motor maximum
`timescale 1ns/1ps
module speed_clamp (
  input wire logic [15:0] speed_i,                 // requested speed
  input wire logic [15:0] max_speed_i,             // motor maximum
  output logic [15:0] speed_o                      // limited speed
);
  logic [15:0] ranged;

  always_comb begin
    ranged = (speed_i > ctl_sel_pkg::SPEED_LIMIT) ?
             ctl_sel_pkg::SPEED_LIMIT : speed_i;
    speed_o = (ranged > max_speed_i) ? max_speed_i : ranged;
  end

endmodule : speed_clamp

// ===== hdl/ctl_method_sel.sv
// control method selector: decodes contacts into method, speed, direction
//
// What this block does
// - the method pair comes from the code taken at restart, 4 to 9.
// - code a toggles speed/zero clamp, code b position/inhibit.
// - factory, codes 4-6: a and b off runs the pair, else internal.
// - internal: b only speed 1, a and b speed 2, a only speed 3.
// - internal turns forward with direction off, reverse with it on.
// - entry into internal set speed is taken at any time.
// - speed select changes take effect within 2 ms.
// - internal to position decelerates, then waits for standstill.
// - changed, codes 4-6: switch on runs the pair, off internal.
// - changed, switch off: dedicated inputs pick speed 0 to 3, way.
// - factory, codes 7-9: direction select picks within the pair.
// - changed, codes 7-9: the control switch picks within the pair.
// - set speeds 0 to 10000 act at once, cut to the motor maximum.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module ctl_method_sel #(
  parameter int unsigned CYCLES_PER_MS = ctl_sel_pkg::CYCLES_PER_MS
) (
  input wire logic clk_i,                          // control clock, 40 MHz
  input wire logic reset_n_i,                      // async reset, low
  input wire logic [7:0] addr_i,                   // register address
  input wire logic [15:0] wdata_i,                 // write data
  input wire logic wr_i,                           // write strobe
  input wire logic rd_i,                           // read strobe
  output logic [15:0] rdata_o,                     // read data, next cycle
  input wire ctl_sel_pkg::seq_in_t contacts_i,     // raw sequence contacts
  input wire logic motor_stopped_i,                // speed loop: at rest
  output ctl_sel_pkg::drive_cmd_t cmd_o            // drive command
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_DECEL = 2'b10
  } sw_state_t;

  ctl_sel_pkg::seq_in_t seq;
  logic [3:0] method_sel_q;
  logic alloc_q;
  logic [15:0] speed_one_q;
  logic [15:0] speed_two_q;
  logic [15:0] speed_three_q;
  logic [15:0] decel_time_q;
  logic [15:0] max_speed_q;
  logic [3:0] active_code_q;
  logic active_alloc_q;
  logic restart_q;
  logic [15:0] speed_one_lim;
  logic [15:0] speed_two_lim;
  logic [15:0] speed_three_lim;
  ctl_sel_pkg::method_t req_method;
  logic [1:0] speed_idx;
  logic req_reverse;
  logic [15:0] req_speed;
  sw_state_t state_q;
  ctl_sel_pkg::method_t method_q;
  logic [31:0] tick_q;
  logic [15:0] ms_left_q;
  logic decel_done;
  logic [15:0] speed_q;
  logic reverse_q;
  logic [15:0] status;

  // ---------------------------------------------------------------
  // contact synchroniser
  // ---------------------------------------------------------------
  seq_in_sync u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i(contacts_i),
    .sync_o(seq)
  );

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      method_sel_q <= ctl_sel_pkg::METHOD_SEL_RST;
      alloc_q <= ctl_sel_pkg::ALLOC_RST;
      speed_one_q <= ctl_sel_pkg::SPEED_ONE_RST;
      speed_two_q <= ctl_sel_pkg::SPEED_TWO_RST;
      speed_three_q <= ctl_sel_pkg::SPEED_THREE_RST;
      decel_time_q <= ctl_sel_pkg::DECEL_TIME_RST;
      max_speed_q <= ctl_sel_pkg::MAX_SPEED_RST;
    end else if (wr_i) begin
      case (addr_i)
        ctl_sel_pkg::METHOD_SEL_OFS: method_sel_q <= wdata_i[3:0];
        ctl_sel_pkg::ALLOC_OFS: alloc_q <= wdata_i[0];
        ctl_sel_pkg::SPEED_ONE_OFS: speed_one_q <= wdata_i;
        ctl_sel_pkg::SPEED_TWO_OFS: speed_two_q <= wdata_i;
        ctl_sel_pkg::SPEED_THREE_OFS: speed_three_q <= wdata_i;
        ctl_sel_pkg::DECEL_TIME_OFS: decel_time_q <= wdata_i;
        ctl_sel_pkg::MAX_SPEED_OFS: max_speed_q <= wdata_i;
        default: begin
        end
      endcase
    end
  end

  // a write of bit 0 at the restart offset stands for a drive restart
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= wr_i && (addr_i == ctl_sel_pkg::RESTART_OFS) &&
                   wdata_i[0];
    end
  end

  // ---------------------------------------------------------------
  // restart-time settings
  // ---------------------------------------------------------------
  // the working copies only move on restart so a live edit of the
  // method code cannot jerk the drive into another loop
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      active_code_q <= ctl_sel_pkg::METHOD_SEL_RST;
      active_alloc_q <= ctl_sel_pkg::ALLOC_RST;
    end else if (restart_q) begin
      active_code_q <= method_sel_q;
      active_alloc_q <= alloc_q;
    end
  end

  // ---------------------------------------------------------------
  // set speed limiting, live on every cycle
  // ---------------------------------------------------------------
  speed_clamp u_clamp_one (
    .speed_i(speed_one_q),
    .max_speed_i(max_speed_q),
    .speed_o(speed_one_lim)
  );

  speed_clamp u_clamp_two (
    .speed_i(speed_two_q),
    .max_speed_i(max_speed_q),
    .speed_o(speed_two_lim)
  );

  speed_clamp u_clamp_three (
    .speed_i(speed_three_q),
    .max_speed_i(max_speed_q),
    .speed_o(speed_three_lim)
  );

  // ---------------------------------------------------------------
  // speed and direction decode
  // ---------------------------------------------------------------
  // host must have assigned the dedicated inputs when allocation is
  // changed; unassigned contacts simply read off here
  always_comb begin
    logic sa;
    logic sb;
    sa = active_alloc_q ? seq.dedicated_speed_a_in :
         seq.speed_select_a_in;
    sb = active_alloc_q ? seq.dedicated_speed_b_in :
         seq.speed_select_b_in;
    req_reverse = active_alloc_q ? seq.dedicated_direction_in :
                  seq.direction_select_in;
    case ({sa, sb})
      2'b01: speed_idx = 2'h1;
      2'b11: speed_idx = 2'h2;
      2'b10: speed_idx = 2'h3;
      default: speed_idx = 2'h0;
    endcase
    case (speed_idx)
      2'h1: req_speed = speed_one_lim;
      2'h2: req_speed = speed_two_lim;
      2'h3: req_speed = speed_three_lim;
      default: req_speed = 16'h0000;
    endcase
  end

  // ---------------------------------------------------------------
  // control method decode
  // ---------------------------------------------------------------
  always_comb begin
    logic both_off;
    logic sw;
    ctl_sel_pkg::method_t paired;
    both_off = !seq.speed_select_a_in && !seq.speed_select_b_in;
    // the switching contact moves to the control switch when the
    // allocation is changed
    sw = active_alloc_q ? seq.control_switch_in :
         seq.direction_select_in;
    case (active_code_q)
      ctl_sel_pkg::CODE_INT_POS: paired = ctl_sel_pkg::M_POSITION;
      ctl_sel_pkg::CODE_INT_TORQUE: paired = ctl_sel_pkg::M_TORQUE;
      default: paired = ctl_sel_pkg::M_SPEED;
    endcase
    case (active_code_q)
      ctl_sel_pkg::CODE_SPEED: req_method = ctl_sel_pkg::M_SPEED;
      ctl_sel_pkg::CODE_POSITION: req_method = ctl_sel_pkg::M_POSITION;
      ctl_sel_pkg::CODE_TORQUE: req_method = ctl_sel_pkg::M_TORQUE;
      ctl_sel_pkg::CODE_INTERNAL: req_method = ctl_sel_pkg::M_INTERNAL;
      ctl_sel_pkg::CODE_INT_SPEED,
      ctl_sel_pkg::CODE_INT_POS,
      ctl_sel_pkg::CODE_INT_TORQUE: begin
        if (active_alloc_q) begin
          req_method = seq.control_switch_in ? paired :
                       ctl_sel_pkg::M_INTERNAL;
        end else begin
          req_method = both_off ? paired :
                       ctl_sel_pkg::M_INTERNAL;
        end
      end
      ctl_sel_pkg::CODE_POS_SPEED: begin
        req_method = sw ? ctl_sel_pkg::M_SPEED :
                     ctl_sel_pkg::M_POSITION;
      end
      ctl_sel_pkg::CODE_POS_TORQUE: begin
        req_method = sw ? ctl_sel_pkg::M_TORQUE :
                     ctl_sel_pkg::M_POSITION;
      end
      ctl_sel_pkg::CODE_TORQUE_SPEED: begin
        req_method = sw ? ctl_sel_pkg::M_SPEED :
                     ctl_sel_pkg::M_TORQUE;
      end
      ctl_sel_pkg::CODE_ZERO_CLAMP: begin
        req_method = (active_alloc_q ? seq.zero_clamp_in :
                     seq.direction_select_in) ?
                     ctl_sel_pkg::M_ZERO_CLAMP :
                     ctl_sel_pkg::M_SPEED;
      end
      ctl_sel_pkg::CODE_INHIBIT: begin
        req_method = (active_alloc_q ? seq.pulse_inhibit_in :
                     seq.direction_select_in) ?
                     ctl_sel_pkg::M_INHIBIT :
                     ctl_sel_pkg::M_POSITION;
      end
      default: req_method = ctl_sel_pkg::M_SPEED;
    endcase
  end

  // ---------------------------------------------------------------
  // deceleration timer
  // ---------------------------------------------------------------
  assign decel_done = (ms_left_q == 16'h0000);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_q <= 32'h0000_0000;
      ms_left_q <= 16'h0000;
    end else if (state_q != ST_DECEL) begin
      tick_q <= 32'h0000_0000;
      ms_left_q <= decel_time_q;
    end else if (!decel_done) begin
      if (tick_q == CYCLES_PER_MS - 1) begin
        tick_q <= 32'h0000_0000;
        ms_left_q <= ms_left_q - 16'h0001;
      end else begin
        tick_q <= tick_q + 32'h0000_0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // method switching state machine
  // ---------------------------------------------------------------
  // entry into internal set speed is never delayed; only the way out
  // towards position control waits for the motor
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_RUN;
      method_q <= ctl_sel_pkg::M_SPEED;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (method_q == ctl_sel_pkg::M_INTERNAL &&
              req_method == ctl_sel_pkg::M_POSITION) begin
            state_q <= ST_DECEL;
          end else begin
            method_q <= req_method;
          end
        end
        ST_DECEL: begin
          if (req_method != ctl_sel_pkg::M_POSITION) begin
            state_q <= ST_RUN;
            method_q <= req_method;
          end else if (decel_done && motor_stopped_i) begin
            state_q <= ST_RUN;
            method_q <= ctl_sel_pkg::M_POSITION;
          end
        end
        default: begin
          state_q <= ST_RUN;
          method_q <= ctl_sel_pkg::M_SPEED;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // speed reference and direction
  // ---------------------------------------------------------------
  // two sync flops plus one here keep the select latency far under
  // the allowed bound, with or without soft start downstream
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      speed_q <= 16'h0000;
      reverse_q <= 1'b0;
    end else if (state_q == ST_DECEL) begin
      speed_q <= 16'h0000;
    end else begin
      speed_q <= req_speed;
      reverse_q <= req_reverse;
    end
  end

  always_comb begin
    cmd_o.method = method_q;
    // zero while decelerating, also in the cycle the state is entered
    cmd_o.speed_ref = (method_q == ctl_sel_pkg::M_INTERNAL &&
                       state_q != ST_DECEL) ? speed_q : 16'h0000;
    cmd_o.reverse = reverse_q;
    cmd_o.decel = (state_q == ST_DECEL);
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  always_comb begin
    status = 16'h0000;
    status[ctl_sel_pkg::ST_METHOD_LSB +: 6] = method_q;
    status[ctl_sel_pkg::ST_REVERSE_BIT] = reverse_q;
    status[ctl_sel_pkg::ST_DECEL_BIT] = (state_q == ST_DECEL);
    status[ctl_sel_pkg::ST_CODE_LSB +: 4] = active_code_q;
    status[ctl_sel_pkg::ST_ALLOC_BIT] = active_alloc_q;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        ctl_sel_pkg::METHOD_SEL_OFS: rdata_o <= {12'h000, method_sel_q};
        ctl_sel_pkg::ALLOC_OFS: rdata_o <= {15'h0000, alloc_q};
        ctl_sel_pkg::SPEED_ONE_OFS: rdata_o <= speed_one_q;
        ctl_sel_pkg::SPEED_TWO_OFS: rdata_o <= speed_two_q;
        ctl_sel_pkg::SPEED_THREE_OFS: rdata_o <= speed_three_q;
        ctl_sel_pkg::DECEL_TIME_OFS: rdata_o <= decel_time_q;
        ctl_sel_pkg::MAX_SPEED_OFS: rdata_o <= max_speed_q;
        ctl_sel_pkg::STATUS_OFS: rdata_o <= status;
        default: rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end

endmodule : ctl_method_sel

// ===== testbench/ctl_method_sel_chk.sv
// port assertions for the control method selector
`timescale 1ns/1ps
module ctl_method_sel_chk #(
  parameter int unsigned CYCLES_PER_MS = ctl_sel_pkg::CYCLES_PER_MS
) (
  input wire logic clk_i, // clock
  input wire logic reset_n_i, // reset, low
  input wire logic [7:0] addr_i, // address
  input wire logic [15:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic [15:0] rdata_o, // read data
  input wire ctl_sel_pkg::seq_in_t contacts_i, // raw contacts
  input wire logic motor_stopped_i, // motor at rest
  input wire ctl_sel_pkg::drive_cmd_t cmd_o // drive command
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_rdata_idle: assert property (
    !$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data not idle");
  a_ref_zero: assert property (
    cmd_o.method != ctl_sel_pkg::M_INTERNAL |-> cmd_o.speed_ref == 16'h0000)
    else $error("speed ref outside internal mode");
  a_method_onehot: assert property (
    $onehot(cmd_o.method))
    else $error("method not one-hot");
  a_speed_cap: assert property (
    cmd_o.speed_ref <= ctl_sel_pkg::SPEED_LIMIT)
    else $error("speed ref above limit");
  a_no_glitch: assert property (
    $changed(contacts_i) |=> $stable(cmd_o.method))
    else $error("method moved before sync delay");
  a_decel_mode: assert property (
    cmd_o.decel |-> cmd_o.method == ctl_sel_pkg::M_INTERNAL &&
      cmd_o.speed_ref == 16'h0000)
    else $error("decel outside internal at zero ref");
  a_decel_start: assert property (
    $rose(cmd_o.decel) |-> $past(cmd_o.method) == ctl_sel_pkg::M_INTERNAL)
    else $error("decel began outside internal");
  a_pos_stopped: assert property (
    cmd_o.method == ctl_sel_pkg::M_POSITION && $past(cmd_o.decel)
      |-> $past(motor_stopped_i))
    else $error("position entered while turning");
endmodule : ctl_method_sel_chk

// ===== testbench/contact_host.sv
// host controller model driving the sequence contacts
`timescale 1ns/1ps
module contact_host (
  input wire logic clk_i, // clock
  input wire logic reset_n_i, // reset, low
  input wire ctl_sel_pkg::seq_in_t want_i, // wanted contacts
  input wire logic [3:0] lag_i, // hold-back cycles
  output ctl_sel_pkg::seq_in_t contacts_o // contacts at the device
);
  logic [3:0] wait_q;
  // a slow host holds a new pattern back; inputs are only relied on
  // once the allocation has been written
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      contacts_o <= '0;
      wait_q <= 4'h0;
    end else if (want_i == contacts_o) begin
      wait_q <= 4'h0;
    end else if (wait_q >= lag_i) begin
      contacts_o <= want_i;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : contact_host

// ===== testbench/ctl_method_sel_tb.sv
// self-checking bench for the control method selector
`timescale 1ns/1ps
module ctl_method_sel_tb;
  logic clk_i = 1'b0, reset_n_i = 1'b0;
  logic wr = 1'b0, rd = 1'b0, rd_q = 1'b0, look = 1'b0, stp = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000, rdata, v;
  logic [3:0] lag = 4'h0;
  ctl_sel_pkg::seq_in_t want = '0, contacts;
  ctl_sel_pkg::drive_cmd_t cmd;
  ctl_sel_pkg::method_t m;
  logic [23:0] expq [$];
  logic [23:0] got, e;
  logic [15:0] lim [0:3];
  int fails = 0, checks_done = 0, seed = 86, i, c, j, alt;
  always #12.5 clk_i = ~clk_i;
  contact_host i_contact_host (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .want_i(want), .lag_i(lag), .contacts_o(contacts));
  ctl_method_sel #(.CYCLES_PER_MS(4)) i_ctl_method_sel (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .contacts_i(contacts),
    .motor_stopped_i(stp), .cmd_o(cmd));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task check(input logic [23:0] g, input logic [23:0] x);
    checks_done++;
    if (g !== x) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, g, x);
    end
  endtask : check
  task test_done();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  task wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [7:0] a, input logic [15:0] x);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    expq.push_back({8'h00, x});
    @(posedge clk_i);
    rd <= 1'b0;
  endtask : rd_reg
  // the wait covers host lag, two sync flops and the state edge
  task look_cmd(input logic [23:0] x);
    repeat (12) @(posedge clk_i);
    expq.push_back(x);
    look <= 1'b1;
    @(posedge clk_i);
    look <= 1'b0;
  endtask : look_cmd
  task restart(input logic [3:0] k, input logic al);
    wr_reg(8'h00, {12'h000, k});
    wr_reg(8'h01, {15'h0000, al});
    wr_reg(8'h08, 16'h0001);
    repeat (4) @(posedge clk_i);
  endtask : restart
  function automatic ctl_sel_pkg::method_t pick(logic [3:0] k, logic al,
                                                logic s);
    if (k < 4'h7) return (al && !s) ? ctl_sel_pkg::M_INTERNAL :
      (k == 4'h4) ? ctl_sel_pkg::M_SPEED : (k == 4'h5) ?
      ctl_sel_pkg::M_POSITION : ctl_sel_pkg::M_TORQUE;
    case (k)
      4'h7: return s ? ctl_sel_pkg::M_SPEED : ctl_sel_pkg::M_POSITION;
      4'h8: return s ? ctl_sel_pkg::M_TORQUE : ctl_sel_pkg::M_POSITION;
      4'h9: return s ? ctl_sel_pkg::M_SPEED : ctl_sel_pkg::M_TORQUE;
      4'ha: return s ? ctl_sel_pkg::M_ZERO_CLAMP : ctl_sel_pkg::M_SPEED;
      default: return s ? ctl_sel_pkg::M_INHIBIT : ctl_sel_pkg::M_POSITION;
    endcase
  endfunction : pick
  // reverse carries no meaning outside a turning internal speed
  always @(posedge clk_i) begin
    if (rd_q || look) begin
      got = rd_q ? {8'h00, rdata} : 24'(cmd);
      e = expq.pop_front();
      if (look && (e[23:18] != 6'h01 || e[17:2] == 16'h0000)) got[1] = e[1];
      check(got, e);
    end
    rd_q <= rd;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd_reg(8'h02, ctl_sel_pkg::SPEED_ONE_RST);
    rd_reg(8'h04, ctl_sel_pkg::SPEED_THREE_RST);
    rd_reg(8'h06, ctl_sel_pkg::MAX_SPEED_RST);
    wr_reg(8'h07, 16'hffff);
    rd_reg(8'h07, {3'h0, ctl_sel_pkg::ALLOC_RST,
      ctl_sel_pkg::METHOD_SEL_RST, 2'b00, ctl_sel_pkg::M_SPEED});
    rd_reg(8'h20, 16'h0000);
    wr_reg(8'h06, 16'h1388);
    lim[0] = 16'h0000;
    for (i = 1; i < 4; i++) begin
      v = 16'($random(seed)) & 16'h1fff;
      wr_reg(8'(i + 1), v);
      rd_reg(8'(i + 1), v);
      lim[i] = (v > 16'h1388) ? 16'h1388 : v;
    end
    for (alt = 0; alt < 2; alt++) begin
      restart(4'h4, alt[0]);
      for (i = 0; i < 8; i++) begin
        lag <= 4'($random(seed)) & 4'h3;
        want <= alt ? 9'(i << 3) : 9'(i << 6);
        m = (i[1:0] != 2'b00 || alt) ? ctl_sel_pkg::M_INTERNAL :
          ctl_sel_pkg::M_SPEED;
        look_cmd({m, (m == ctl_sel_pkg::M_SPEED) ? 16'h0000 : lim[i[0] ?
          (i[1] ? 2 : 1) : (i[1] ? 3 : 0)], i[2], 1'b0});
      end
      for (c = 4; c < 12; c++) begin
        restart(4'(c), alt[0]);
        for (j = 0; j < 2; j++) begin
          want <= alt ? {~j[0], 5'h00, {3{j[0]}}} : {j[0], 5'h00, {3{~j[0]}}};
          look_cmd({pick(4'(c), alt[0], j[0]), 18'h00000});
        end
      end
    end
    restart(4'h5, 1'b0);
    wr_reg(8'h05, 16'h0002);
    stp <= 1'b0;
    want <= 9'h040;
    look_cmd({ctl_sel_pkg::M_INTERNAL, lim[1], 2'b00});
    want <= 9'h000;
    look_cmd({ctl_sel_pkg::M_INTERNAL, 18'h00001});
    stp <= 1'b1;
    look_cmd({ctl_sel_pkg::M_POSITION, 18'h00000});
    want <= 9'h040;
    look_cmd({ctl_sel_pkg::M_INTERNAL, lim[1], 2'b00});
    want <= 9'h000;
    look_cmd({ctl_sel_pkg::M_INTERNAL, 18'h00001});
    wr_reg(8'h00, 16'h0009);
    look_cmd({ctl_sel_pkg::M_POSITION, 18'h00000});
    stp <= 1'b0;
    want <= 9'h140;
    look_cmd({ctl_sel_pkg::M_INTERNAL, lim[1], 2'b10});
    @(posedge clk_i);
    test_done();
  end
endmodule : ctl_method_sel_tb
bind ctl_method_sel ctl_method_sel_chk #(.CYCLES_PER_MS(CYCLES_PER_MS))
  i_ctl_method_sel_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .contacts_i(contacts_i),
  .motor_stopped_i(motor_stopped_i), .cmd_o(cmd_o));
